// file: logic/exec_pkg.sv
package exec_pkg;

    // ****************************************
    // Opcode values and decode masks
    // ****************************************
    localparam logic [7:0] OP_DECIMAL_ADJUST = 8'hD4;
    localparam logic [7:0] OP_SUB_ONE_ACC = 8'h14;
    localparam logic [7:0] OP_SUB_ONE_DIR = 8'h15;
    localparam logic [7:0] OP_SUB_ONE_BANK = 8'h18;
    localparam logic [7:0] OP_SUB_ONE_IND = 8'h16;
    localparam logic [7:0] OP_ADD_ONE_ACC = 8'h04;
    localparam logic [7:0] OP_ADD_ONE_DIR = 8'h05;
    localparam logic [7:0] OP_ADD_ONE_BANK = 8'h08;
    localparam logic [7:0] OP_ADD_ONE_IND = 8'h06;
    localparam logic [7:0] OP_DIVIDE = 8'h84;
    localparam logic [7:0] OP_COUNT_DOWN_BANK = 8'hD8;
    localparam logic [7:0] OP_COUNT_DOWN_DIR = 8'hD5;
    localparam logic [7:0] OP_POINTER_INC = 8'hA3;
    localparam logic [7:0] OP_BRANCH_IF_BIT_SET = 8'h20;
    localparam logic [7:0] OP_BRANCH_BIT_SET_THEN_CLEAR = 8'h10;
    localparam logic [7:0] OP_BRANCH_IF_CARRY = 8'h40;
    localparam logic [7:0] MASK_BANK = 8'hF8;
    localparam logic [7:0] MASK_IND = 8'hFE;

    // ****************************************
    // Arithmetic constants and cycle counts
    // ****************************************
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [8:0] BCD_LOW_FIX = 9'h006;
    localparam logic [8:0] BCD_HIGH_FIX = 9'h060;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam int CYCLES_SHORT = 1;
    localparam int CYCLES_LONG = 2;

    // ****************************************
    // Request and result carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [15:0] pc_next;
        logic [7:0] acc;
        logic [7:0] b_reg;
        logic [7:0] operand_pin;
        logic [7:0] operand_latch;
        logic operand_is_port;
        logic bit_pin;
        logic bit_latch;
        logic bit_is_port;
        logic [15:0] data_pointer;
        logic carry;
        logic auxiliary_carry;
        logic arith_error_flag;
    } exec_req_type;

    typedef struct packed {
        logic [7:0] acc;
        logic acc_we;
        logic [7:0] b_reg;
        logic b_we;
        logic [7:0] operand;
        logic operand_we;
        logic bit_clear;
        logic carry;
        logic carry_we;
        logic arith_error_flag;
        logic arith_error_we;
        logic [15:0] data_pointer;
        logic data_pointer_we;
        logic branch_taken;
        logic [15:0] target;
        logic unknown_opcode;
    } exec_res_type;

endpackage

// file: logic/bcd_incdec_divide_branch_exec.sv
`timescale 1ns/1ps
module bcd_incdec_divide_branch_exec #(
    parameter int PC_WIDTH = 16
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Request
    input wire logic i_start,
    input wire exec_pkg::exec_req_type i_req,
    output logic o_ready,
    // Result
    output logic o_done,
    output exec_pkg::exec_res_type o_res
);

    // ****************************************
    // Parameter check
    // ****************************************
    if (PC_WIDTH != 16) begin : g_bad_pc
        $error("PC_WIDTH must be 16");
    end
    // The sequencer has a single extra state, so only one- and two-cycle counts can be served
    if ((exec_pkg::CYCLES_SHORT != 1) || (exec_pkg::CYCLES_LONG != 2)) begin : g_bad_cycles
        $error("Cycle counts must be one and two");
    end

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SECOND
    } state_type;

    state_type state_q;
    logic done_q;
    exec_pkg::exec_res_type res_q;
    exec_pkg::exec_res_type res_d;
    int cycles_d;

    logic take;
    logic [7:0] opnd;
    logic bit_now;
    logic [7:0] offset;
    logic [15:0] branch_target;
    logic [8:0] da_low;
    logic [8:0] da_high;
    logic da_carry_mid;
    logic [7:0] op_minus;
    logic [7:0] op_plus;
    logic is_adjust;
    logic is_sub_acc;
    logic is_sub_mem;
    logic is_add_acc;
    logic is_add_mem;
    logic is_divide;
    logic is_count_bank;
    logic is_count_down;
    logic is_pointer_inc;
    logic is_bit_set;
    logic is_bit_clear;
    logic is_carry_branch;
    logic [7:0] div_rem [0:8];
    logic [7:0] div_quot;

    assign take = i_start && (state_q == ST_IDLE);
    assign o_ready = (state_q == ST_IDLE);
    assign o_done = done_q;
    assign o_res = res_q;

    // ****************************************
    // Instruction decode
    // ****************************************
    // Bank and indirect forms carry the register number in the low opcode bits, so those bits are masked
    assign is_adjust = (i_req.opcode == exec_pkg::OP_DECIMAL_ADJUST);
    assign is_sub_acc = (i_req.opcode == exec_pkg::OP_SUB_ONE_ACC);
    assign is_sub_mem = (i_req.opcode == exec_pkg::OP_SUB_ONE_DIR) ||
                        ((i_req.opcode & exec_pkg::MASK_BANK) == exec_pkg::OP_SUB_ONE_BANK) ||
                        ((i_req.opcode & exec_pkg::MASK_IND) == exec_pkg::OP_SUB_ONE_IND);
    assign is_add_acc = (i_req.opcode == exec_pkg::OP_ADD_ONE_ACC);
    assign is_add_mem = (i_req.opcode == exec_pkg::OP_ADD_ONE_DIR) ||
                        ((i_req.opcode & exec_pkg::MASK_BANK) == exec_pkg::OP_ADD_ONE_BANK) ||
                        ((i_req.opcode & exec_pkg::MASK_IND) == exec_pkg::OP_ADD_ONE_IND);
    assign is_divide = (i_req.opcode == exec_pkg::OP_DIVIDE);
    assign is_count_bank = ((i_req.opcode & exec_pkg::MASK_BANK) == exec_pkg::OP_COUNT_DOWN_BANK);
    assign is_count_down = is_count_bank || (i_req.opcode == exec_pkg::OP_COUNT_DOWN_DIR);
    assign is_pointer_inc = (i_req.opcode == exec_pkg::OP_POINTER_INC);
    assign is_bit_set = (i_req.opcode == exec_pkg::OP_BRANCH_IF_BIT_SET);
    assign is_bit_clear = (i_req.opcode == exec_pkg::OP_BRANCH_BIT_SET_THEN_CLEAR);
    assign is_carry_branch = (i_req.opcode == exec_pkg::OP_BRANCH_IF_CARRY);

    // ****************************************
    // Operand sources
    // ****************************************
    // A port operand that is modified must come from the latch; pins may be loaded externally
    assign opnd = i_req.operand_is_port ? i_req.operand_latch : i_req.operand_pin;
    assign bit_now = i_req.bit_is_port ? i_req.bit_latch : i_req.bit_pin;
    assign op_minus = opnd - exec_pkg::BYTE_ONE;
    assign op_plus = opnd + exec_pkg::BYTE_ONE;

    // ****************************************
    // Relative target
    // ****************************************
    always_comb begin
        offset = i_req.byte3;
        if (is_count_bank || is_carry_branch) begin
            offset = i_req.byte2;
        end
    end

    // Carry out of bit 15 is dropped, so the sum wraps
    assign branch_target = i_req.pc_next + {{8{offset[7]}}, offset};

    // ****************************************
    // Decimal adjust arithmetic
    // ****************************************
    always_comb begin
        da_low = {1'b0, i_req.acc};
        if ((i_req.acc[3:0] > exec_pkg::BCD_DIGIT_MAX) || i_req.auxiliary_carry) begin
            da_low = {1'b0, i_req.acc} + exec_pkg::BCD_LOW_FIX;
        end
        da_carry_mid = i_req.carry | da_low[8];
        da_high = {1'b0, da_low[7:0]};
        if ((da_low[7:4] > exec_pkg::BCD_DIGIT_MAX) || da_carry_mid) begin
            da_high = {1'b0, da_low[7:0]} + exec_pkg::BCD_HIGH_FIX;
        end
    end

    // ****************************************
    // Unsigned divide
    // ****************************************
    // Restoring divider unrolled into eight stages so the divide ends in one cycle; the cost is a long subtract chain
    assign div_rem[0] = exec_pkg::BYTE_ZERO;
    for (genvar k = 0; k < 8; k++) begin : g_div_stage
        logic [8:0] shifted;
        logic [8:0] trial;
        assign shifted = {div_rem[k], i_req.acc[7 - k]};
        // Bit 8 of the trial difference is the borrow: set when the divisor does not fit
        assign trial = shifted - {1'b0, i_req.b_reg};
        assign div_quot[7 - k] = ~trial[8];
        assign div_rem[k + 1] = trial[8] ? shifted[7:0] : trial[7:0];
    end

    // ****************************************
    // Execute decode
    // ****************************************
    always_comb begin
        res_d = '0;
        res_d.target = i_req.pc_next;
        cycles_d = exec_pkg::CYCLES_SHORT;
        if (is_adjust) begin
            res_d.acc = da_high[7:0];
            res_d.acc_we = 1'b1;
            // Carry may only rise; the error flag is not written at all
            res_d.carry = da_carry_mid | da_high[8];
            res_d.carry_we = 1'b1;
        end else if (is_sub_acc) begin
            res_d.acc = i_req.acc - exec_pkg::BYTE_ONE;
            res_d.acc_we = 1'b1;
        end else if (is_sub_mem) begin
            res_d.operand = op_minus;
            res_d.operand_we = 1'b1;
        end else if (is_add_acc) begin
            res_d.acc = i_req.acc + exec_pkg::BYTE_ONE;
            res_d.acc_we = 1'b1;
        end else if (is_add_mem) begin
            res_d.operand = op_plus;
            res_d.operand_we = 1'b1;
        end else if (is_divide) begin
            res_d.carry_we = 1'b1;
            res_d.arith_error_we = 1'b1;
            res_d.carry = 1'b0;
            if (i_req.b_reg == exec_pkg::BYTE_ZERO) begin
                // Quotient and remainder are undefined; both registers are left as they were
                res_d.arith_error_flag = 1'b1;
            end else begin
                res_d.acc = div_quot;
                res_d.b_reg = div_rem[8];
                res_d.acc_we = 1'b1;
                res_d.b_we = 1'b1;
            end
        end else if (is_count_down) begin
            cycles_d = exec_pkg::CYCLES_LONG;
            res_d.operand = op_minus;
            res_d.operand_we = 1'b1;
            if (op_minus != exec_pkg::BYTE_ZERO) begin
                res_d.branch_taken = 1'b1;
                res_d.target = branch_target;
            end
        end else if (is_pointer_inc) begin
            cycles_d = exec_pkg::CYCLES_LONG;
            res_d.data_pointer = i_req.data_pointer + exec_pkg::WORD_ONE;
            res_d.data_pointer_we = 1'b1;
        end else if (is_bit_set) begin
            cycles_d = exec_pkg::CYCLES_LONG;
            if (i_req.bit_pin) begin
                res_d.branch_taken = 1'b1;
                res_d.target = branch_target;
            end
        end else if (is_bit_clear) begin
            cycles_d = exec_pkg::CYCLES_LONG;
            if (bit_now) begin
                res_d.bit_clear = 1'b1;
                res_d.branch_taken = 1'b1;
                res_d.target = branch_target;
            end
        end else if (is_carry_branch) begin
            cycles_d = exec_pkg::CYCLES_LONG;
            if (i_req.carry) begin
                res_d.branch_taken = 1'b1;
                res_d.target = branch_target;
            end
        end else begin
            res_d.unknown_opcode = 1'b1;
        end
    end

    // ****************************************
    // Sequencing
    // ****************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take && (cycles_d == exec_pkg::CYCLES_LONG)) begin
                        state_q <= ST_SECOND;
                    end
                end
                ST_SECOND: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (take && (cycles_d == exec_pkg::CYCLES_SHORT)) || (state_q == ST_SECOND);
        end
    end

    // Result is held stable from capture until the next request is taken
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            res_q <= '0;
        end else if (take) begin
            res_q <= res_d;
        end
    end

endmodule

// file: test/exec_props.sv
`timescale 1ns/1ps
module exec_props (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Request and result
    input wire logic i_start,
    input wire exec_pkg::exec_req_type i_req,
    input wire logic o_ready,
    input wire logic o_done,
    input wire exec_pkg::exec_res_type o_res
);
    // ****
    // Decode helpers
    // ****
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic tk;
    logic lng;
    logic [7:0] op;
    logic [15:0] carry_target;
    logic clear_expected;
    assign op = i_req.opcode;
    // Expectations are formed on the taking edge and compared one cycle later through a plain $past
    assign carry_target = i_req.carry ? i_req.pc_next + {{8{i_req.byte2[7]}}, i_req.byte2} : i_req.pc_next;
    assign clear_expected = (op == 8'h10) && (i_req.bit_is_port ? i_req.bit_latch : i_req.bit_pin);
    assign tk = i_start & o_ready;
    assign lng = op inside {8'hA3, 8'h20, 8'h10, 8'h40, 8'hD5, [8'hD8:8'hDF]};
    sequence s_busy;
        !o_ready && !o_done;
    endsequence
    sequence s_answer;
        o_ready && o_done;
    endsequence
    a_short_answer: assert property (tk && !lng |=> o_done)
        else $error("one-cycle answer missing");
    a_long_answer: assert property (tk && lng |=> s_busy ##1 s_answer)
        else $error("two-cycle answer wrong");
    a_ptr_step: assert property (tk && op == 8'hA3 |=> o_res.data_pointer_we &&
        o_res.data_pointer == $past(i_req.data_pointer) + 16'h0001) else $error("pointer step wrong");
    a_div_flags: assert property (tk && op == 8'h84 |=> o_res.carry_we && !o_res.carry &&
        o_res.arith_error_we && (o_res.arith_error_flag == ($past(i_req.b_reg) == 8'h00)))
        else $error("divide flags wrong");
    a_adjust_carry: assert property (tk && op == 8'hD4 && i_req.carry |=>
        o_res.carry && !o_res.arith_error_we) else $error("adjust lost carry");
    a_step_flags: assert property (tk && op inside {[8'h04:8'h0F], [8'h14:8'h1F], [8'hD8:8'hDF], 8'hD5}
        |=> !o_res.carry_we && !o_res.arith_error_we) else $error("step touched flags");
    a_carry_branch: assert property (tk && op == 8'h40 |=> o_res.branch_taken == $past(i_req.carry) &&
        o_res.target == $past(carry_target)) else $error("carry branch wrong");
    a_bit_clear: assert property (tk && op inside {8'h10, 8'h20} |=> o_res.bit_clear ==
        $past(clear_expected)) else $error("bit clear wrong");
endmodule

bind bcd_incdec_divide_branch_exec exec_props i_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_start(i_start), .i_req(i_req), .o_ready(o_ready), .o_done(o_done), .o_res(o_res));

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_start = 1'b0;
    exec_pkg::exec_req_type i_req = '0;
    logic o_ready;
    logic o_done;
    exec_pkg::exec_res_type o_res;
    exec_pkg::exec_req_type r;
    logic [31:0] seed = 32'h8d1b_f35e;
    int num_errors = 0;
    int checks = 0;

    bcd_incdec_divide_branch_exec #(.PC_WIDTH(16)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_start(i_start), .i_req(i_req), .o_ready(o_ready), .o_done(o_done), .o_res(o_res));

    initial begin
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // ****
    // Stimulus and expectations
    // ****
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Biased towards the wrap points so boundaries come up often
    function automatic logic [7:0] edge8(logic [31:0] w);
        return (w[1:0] == 2'h0) ? 8'h00 : (w[1:0] == 2'h1) ? 8'hFF : w[9:2];
    endfunction

    function automatic exec_pkg::exec_req_type rnd_req();
        exec_pkg::exec_req_type q;
        q = 95'({xs(), xs(), xs()});
        q.acc = edge8(xs());
        q.b_reg = edge8(xs());
        q.operand_pin = edge8(xs());
        q.operand_latch = edge8(xs());
        q.data_pointer[7:0] = edge8(xs());
        return q;
    endfunction

    function automatic int cyc(logic [7:0] op);
        return (op inside {8'hA3, 8'h20, 8'h10, 8'h40, 8'hD5, [8'hD8:8'hDF]}) ? 2 : 1;
    endfunction

    function automatic exec_pkg::exec_res_type model(exec_pkg::exec_req_type q);
        exec_pkg::exec_res_type e;
        logic [7:0] v;
        logic [7:0] off;
        logic [8:0] s;
        logic c;
        e = '0;
        e.target = q.pc_next;
        v = q.operand_is_port ? q.operand_latch : q.operand_pin;
        off = q.byte3;
        s = {1'b0, q.acc};
        casez (q.opcode)
            8'hD4: begin
                if (s[3:0] > 4'h9 || q.auxiliary_carry) s = s + 9'h006;
                c = q.carry | s[8];
                if (s[7:4] > 4'h9 || c) s = {1'b0, s[7:0]} + 9'h060;
                {e.acc, e.acc_we, e.carry, e.carry_we} = {s[7:0], 1'b1, c | s[8], 1'b1};
            end
            8'h14: {e.acc, e.acc_we} = {q.acc - 8'h01, 1'b1};
            8'h04: {e.acc, e.acc_we} = {q.acc + 8'h01, 1'b1};
            8'b0001_1???, 8'h15, 8'b0001_011?: {e.operand, e.operand_we} = {v - 8'h01, 1'b1};
            8'b0000_1???, 8'h05, 8'b0000_011?: {e.operand, e.operand_we} = {v + 8'h01, 1'b1};
            8'h84: begin
                {e.carry_we, e.arith_error_we, e.arith_error_flag} = {2'b11, q.b_reg == 8'h00};
                if (q.b_reg != 8'h00) {e.acc, e.b_reg, e.acc_we, e.b_we} = {q.acc / q.b_reg, q.acc % q.b_reg, 2'b11};
            end
            8'b1101_1???, 8'hD5: begin
                {e.operand, e.operand_we, e.branch_taken} = {v - 8'h01, 1'b1, v != 8'h01};
                if (q.opcode[3]) off = q.byte2;
            end
            8'hA3: {e.data_pointer, e.data_pointer_we} = {q.data_pointer + 16'h0001, 1'b1};
            8'h20: e.branch_taken = q.bit_pin;
            8'h10: {e.branch_taken, e.bit_clear} = {2{q.bit_is_port ? q.bit_latch : q.bit_pin}};
            8'h40: {e.branch_taken, off} = {q.carry, q.byte2};
            default: e.unknown_opcode = 1'b1;
        endcase
        if (e.branch_taken) e.target = q.pc_next + {{8{off[7]}}, off};
        return e;
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic run(input exec_pkg::exec_req_type q);
        int n;
        exec_pkg::exec_res_type e;
        e = model(q);
        @(posedge i_ref_clk);
        i_start <= 1'b1;
        i_req <= q;
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        #1;
        n = 1;
        while (o_done !== 1'b1 && n < 4) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        check(128'(n), 128'(cyc(q.opcode)));
        check(128'(o_res), 128'(e));
        check(128'({o_res.branch_taken, o_res.target}), 128'({e.branch_taken, e.target}));
    endtask

    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        r = rnd_req();
        {r.opcode, r.acc, r.carry, r.auxiliary_carry} = {8'hD4, 8'hBE, 2'b00};
        run(r);
        check(128'({o_res.acc, o_res.carry}), 128'({8'h24, 1'b1}));
        {r.opcode, r.acc, r.b_reg} = {8'h84, 8'hFB, 8'h12};
        run(r);
        check(128'({o_res.acc, o_res.b_reg}), 128'(16'h0D11));
        repeat (3000) run(rnd_req());
        final_report();
    end

    // Runs take under 10000 cycles; a 50000-cycle limit leaves ample margin
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
endmodule
